// ### hw/rtcp_dev.sv
// rtcp_dev: register file, key lock, burst freeze and crystal trim
// assumes: ticks, events and power levels are synchronous to clk
`timescale 1ns/100ps
`include "rtcp_defs.svh"
module rtcp_dev
   import rtcp_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   rtcp_link_if.dev link,
   input wire logic xt_tick,
   input wire logic rc_tick,
   input wire logic [7:0] event_set,
   input wire logic backup_power,
   input wire logic osc_on_rc,
   output logic [31:0] seconds,
   output logic second_pulse,
   output logic chain_frozen,
   output logic bus_disabled,
   output logic output_b_level,
   output logic halt,
   output logic backup_rc_autoswitch,
   output logic osc_source_select,
   output logic [3:0] switchover_threshold,
   output logic [7:0] charge_control,
   output logic [7:0] output_control
);
   rtcp_dev_s q, d;
   logic take, rd, wr, key_ok, tick;
   logic [9:0] fine, dbl, steps;
   logic [15:0] sum;
   logic slot;

   //----------------------------------------------------------------
   // bus gating and trim arithmetic
   //----------------------------------------------------------------
   // no answer at all while in backup with bus io off
   assign bus_disabled = backup_power && !q.bus_io[`RTCP_B_BUS_IO_IN_BACKUP]; // RULE_12
   assign take = link.req && !q.ack && !bus_disabled;
   assign rd = take && !link.we;
   assign wr = take && link.we;
   assign tick = q.oscc[`RTCP_B_OSC_SOURCE_SELECT] ? rc_tick : xt_tick; // RULE_16
   assign fine = {{3{q.xtrim[6]}}, q.xtrim[6:0]};
   // doubled fine units in mode 1, minus 64 steps per coarse unit
   assign dbl = q.xtrim[`RTCP_B_TRIM_MODE] ? {fine[8:0], 1'b0} : fine; // RULE_19
   assign steps = dbl - {2'b00, q.oscc[6:5], 6'h00};
   assign slot = tick && (q.win[`RTCP_SLOT_BITS-1:0] == 10'h000) &&
      (q.left != 9'h000);

   //----------------------------------------------------------------
   // key check for the addressed protected register
   //----------------------------------------------------------------
   always_comb begin
      key_ok = 1'b1;
      if (link.addr == `RTCP_A_OSC_CTRL) begin
         key_ok = (q.key == `RTCP_KEY_OSC); // RULE_01
      end else if (link.addr == `RTCP_A_CHARGE ||
            link.addr == `RTCP_A_SW_REF ||
            link.addr == `RTCP_A_BUS_IO ||
            link.addr == `RTCP_A_OUT_CTRL) begin
         key_ok = (q.key == `RTCP_KEY_MISC); // RULE_02
      end
   end

   //----------------------------------------------------------------
   // next state
   //----------------------------------------------------------------
   always_comb begin
      d = q;
      d.ack = take;
      d.sec = 1'b0;
      // hardware events are or-ed last so a set beats a clear
      if (rd && link.addr == `RTCP_A_EVENT_FLAGS &&
            q.ctrl1[`RTCP_B_CLR_ON_RD]) begin
         d.flags = q.flags & ~`RTCP_FLAG_CLR_MASK; // RULE_07
      end
      if (wr && link.addr == `RTCP_A_EVENT_FLAGS) begin
         d.flags = link.wdata; // RULE_06
      end
      d.flags = d.flags | event_set;

      // register writes; protected ones need the key
      if (wr && key_ok) begin
         if (link.addr == `RTCP_A_CTRL_ONE) begin
            d.ctrl1 = link.wdata;
            if (q.lock) begin
               d.ctrl1[`RTCP_B_OUTPUT_B_LEVEL] = q.ctrl1[`RTCP_B_OUTPUT_B_LEVEL]; // RULE_09
            end
         end else if (link.addr == `RTCP_A_XTAL_TRIM) begin
            d.xtrim = link.wdata;
         end else if (link.addr == `RTCP_A_RC_TRIM_HI) begin
            d.rc_hi = link.wdata;
         end else if (link.addr == `RTCP_A_RC_TRIM_LO) begin
            d.rc_lo = link.wdata;
         end else if (link.addr == `RTCP_A_OSC_CTRL) begin
            d.oscc = link.wdata;
         end else if (link.addr == `RTCP_A_OSC_STATE) begin
            d.lock = link.wdata[`RTCP_B_LOCK];
         end else if (link.addr == `RTCP_A_CHARGE) begin
            d.charge = link.wdata;
         end else if (link.addr == `RTCP_A_SW_REF) begin
            d.sw_ref = link.wdata;
         end else if (link.addr == `RTCP_A_BUS_IO) begin
            d.bus_io = link.wdata;
         end else if (link.addr == `RTCP_A_OUT_CTRL) begin
            d.output_control_reg = link.wdata;
         end
      end
      // any key value is stored, only the two codes ever match
      if (wr && link.addr == `RTCP_A_KEY) begin
         d.key = link.wdata; // RULE_20
      end else if (wr && key_ok && link.addr != `RTCP_A_OSC_STATE &&
            (link.addr == `RTCP_A_OSC_CTRL || link.addr >= `RTCP_A_CHARGE))
            begin
         d.key = 8'h00; // RULE_03
      end
      // a mismatched key leaves the register untouched above RULE_21

      // read mux
      d.rdata = 8'h00;
      if (rd) begin
         if (link.addr <= `RTCP_A_TIME_LAST) begin
            d.rdata = link.addr[2] ? 8'h00 : q.secs[link.addr[1:0]*8 +: 8];
         end else if (link.addr == `RTCP_A_EVENT_FLAGS) begin
            d.rdata = q.flags;
         end else if (link.addr == `RTCP_A_CTRL_ONE) begin
            d.rdata = q.ctrl1;
            if (q.lock) begin
               d.rdata[`RTCP_B_OUTPUT_B_LEVEL] = 1'b0; // RULE_09
            end
         end else if (link.addr == `RTCP_A_XTAL_TRIM) begin
            d.rdata = q.xtrim;
         end else if (link.addr == `RTCP_A_RC_TRIM_HI) begin
            d.rdata = q.rc_hi;
         end else if (link.addr == `RTCP_A_RC_TRIM_LO) begin
            d.rdata = q.rc_lo;
         end else if (link.addr == `RTCP_A_OSC_CTRL) begin
            d.rdata = q.oscc;
         end else if (link.addr == `RTCP_A_OSC_STATE) begin
            d.rdata[`RTCP_B_LOCK] = q.lock;
            // source indication is meaningless while halted
            d.rdata[`RTCP_B_OSC_RUNNING_SOURCE] = osc_on_rc &&
               !q.ctrl1[`RTCP_B_HALT]; // RULE_08
         end else if (link.addr == `RTCP_A_KEY) begin
            d.rdata = q.key;
         end else if (link.addr == `RTCP_A_CHARGE) begin
            d.rdata = q.charge;
         end else if (link.addr == `RTCP_A_SW_REF) begin
            d.rdata = q.sw_ref;
         end else if (link.addr == `RTCP_A_BUS_IO) begin
            d.rdata = q.bus_io;
         end else if (link.addr == `RTCP_A_OUT_CTRL) begin
            d.rdata = q.output_control_reg;
         end
      end

      // freeze starts on a burst read of the time bytes
      if (rd && link.burst && link.addr <= `RTCP_A_TIME_LAST) begin
         d.frozen = 1'b1; // RULE_04
      end else if (!link.burst) begin
         d.frozen = 1'b0;
      end

      // divider chain: one step per tick unless halted, two on add, none on drop
      sum = {1'b0, q.div};
      if (tick && !q.ctrl1[`RTCP_B_HALT]) begin
         if (!slot) begin
            sum = sum + 16'h0001;
         end else if (q.add) begin
            sum = sum + 16'h0002; // RULE_13
         end
         d.win = q.win + 19'h00001;
         if (slot) begin
            d.left = q.left - 9'h001;
         end
         // window of 2^19 ticks, |steps| pulses moved per window
         if (q.win == '0) begin
            d.add = !steps[9];
            d.left = steps[9] ? 9'(-steps) : steps[8:0]; // RULE_14
            // zero trim loads zero pulses and leaves the chain plain RULE_15
         end
      end
      d.div = sum[14:0];
      d.sec = sum[15];
      // a second seen while frozen waits; bursts end well under 1 s
      if (q.frozen) begin
         d.pend = q.pend | q.sec; // RULE_04
      end else begin
         d.pend = 1'b0;
         d.secs = q.secs + {31'h0, q.sec} + {31'h0, q.pend};
      end
   end

   //----------------------------------------------------------------
   // state register
   //----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         q <= '0;
         q.sw_ref <= `RTCP_RST_SW_REF; // RULE_11
         q.bus_io <= `RTCP_RST_BUS_IO; // RULE_12
         // autoswitch bit comes up clear RULE_10
      end else begin
         q <= d;
      end
   end

   //----------------------------------------------------------------
   // outputs
   //----------------------------------------------------------------
   assign link.ack = q.ack;
   assign link.rdata = q.rdata;
   assign seconds = q.secs;
   assign second_pulse = q.sec;
   assign chain_frozen = q.frozen;
   assign output_b_level = q.ctrl1[`RTCP_B_OUTPUT_B_LEVEL];
   assign halt = q.ctrl1[`RTCP_B_HALT];
   assign backup_rc_autoswitch = q.oscc[`RTCP_B_AOS];
   assign osc_source_select = q.oscc[`RTCP_B_OSC_SOURCE_SELECT];
   assign switchover_threshold = q.sw_ref[7:4];
   assign charge_control = q.charge;
   assign output_control = q.output_control_reg;
endmodule

// ### hw/rtcp_defs.svh
// rtcp_defs.svh: offsets, field positions, reset values and timing counts
// assumes: included by the package and by both ends of the register link
//----------------------------------------------------------------------
// Overview of operation
//----------------------------------------------------------------------
// Overview of operation
// [RULE_01] key 0xa1 unlocks one oscillator control access
// [RULE_02] key 0x9d unlocks charge, threshold, bus-io, output control
// [RULE_03] device clears key after protected write
// [RULE_04] time burst read freezes timekeeping until end
// [RULE_05] host ends any time burst within 10 ms
// [RULE_06] every event flag bit readable and writable
// [RULE_07] clear-on-read clears six interrupt flags on read
// [RULE_08] halt set makes running-source indication invalid
// [RULE_09] output lock blocks access to output b bit
// [RULE_10] autoswitch resets 0, host sets it
// [RULE_11] threshold resets 1111, host never changes it
// [RULE_12] bus-io bit resets 1; 0 disables bus in backup
// [RULE_13] trim adds or drops divider pulses only
// [RULE_14] each trim step is one part in 2^19
// [RULE_15] all trim fields zero means no correction
// [RULE_16] source select 0 clocks timekeeping from crystal
// [RULE_17] host derives steps from measured frequency offset
// [RULE_18] host rejects steps below -320
// [RULE_19] host picks coarse, mode, fine by step band
// [RULE_20] other key values grant no access
// [RULE_21] protected write without matching key is ignored
`ifndef RTCP_DEFS_SVH
`define RTCP_DEFS_SVH
`define RTCP_A_EVENT_FLAGS 8'h0f
`define RTCP_A_CTRL_ONE 8'h10
`define RTCP_A_XTAL_TRIM 8'h14
`define RTCP_A_RC_TRIM_HI 8'h15
`define RTCP_A_RC_TRIM_LO 8'h16
`define RTCP_A_OSC_CTRL 8'h1c
`define RTCP_A_OSC_STATE 8'h1d
`define RTCP_A_KEY 8'h1f
`define RTCP_A_CHARGE 8'h20
`define RTCP_A_SW_REF 8'h21
`define RTCP_A_BUS_IO 8'h27
`define RTCP_A_OUT_CTRL 8'h30
`define RTCP_A_TIME_LAST 8'h07
`define RTCP_KEY_OSC 8'ha1
`define RTCP_KEY_MISC 8'h9d
`define RTCP_B_HALT 7
`define RTCP_B_OUTPUT_B_LEVEL 5
`define RTCP_B_CLR_ON_RD 2
`define RTCP_B_OSC_SOURCE_SELECT 7
`define RTCP_B_AOS 4
`define RTCP_B_LOCK 5
`define RTCP_B_OSC_RUNNING_SOURCE 4
`define RTCP_B_BUS_IO_IN_BACKUP 7
`define RTCP_B_TRIM_MODE 7
`define RTCP_FLAG_CLR_MASK 8'h3f
`define RTCP_RST_SW_REF 8'hf0
`define RTCP_RST_BUS_IO 8'h80
`define RTCP_DIV_BITS 15
`define RTCP_WIN_BITS 19
`define RTCP_SLOT_BITS 10
`define RTCP_COARSE_STEP 10'h040
`define RTCP_NOM_Q4 21'h080000
`define RTCP_ADJ_MIN -21'sd320
`define RTCP_ADJ_MAX 21'sd128
`define RTCP_CLK_MHZ 25
`define RTCP_BURST_MS 10
`define RTCP_BURST_CYC (`RTCP_BURST_MS * `RTCP_CLK_MHZ * 1000)
`endif

// ### hw/rtcp_pkg.sv
// rtcp_pkg: state types of both link ends
// assumes: constants come from rtcp_defs.svh
`include "rtcp_defs.svh"
package rtcp_pkg;
   typedef struct packed {
      logic [7:0] flags;
      logic [7:0] ctrl1;
      logic [7:0] xtrim;
      logic [7:0] rc_hi;
      logic [7:0] rc_lo;
      logic [7:0] oscc;
      logic lock;
      logic [7:0] key;
      logic [7:0] charge;
      logic [7:0] sw_ref;
      logic [7:0] bus_io;
      logic [7:0] output_control_reg;
      logic [7:0] rdata;
      logic ack;
      logic frozen;
      logic pend;
      logic [14:0] div;
      logic [18:0] win;
      logic [8:0] left;
      logic add;
      logic sec;
      logic [31:0] secs;
   } rtcp_dev_s;

   typedef enum logic [2:0] {
      H_IDLE = 3'b001,
      H_ISSUE = 3'b010,
      H_DONE = 3'b100
   } rtcp_host_e;

   typedef logic [16:0] rtcp_op_t; // {we, addr, data}

   typedef struct packed {
      rtcp_host_e st;
      rtcp_op_t [3:0] ops;
      logic [2:0] n;
      logic [1:0] i;
      logic rsp_valid;
      logic [7:0] rsp_data;
      logic reject;
      logic burst_to;
      logic [17:0] cnt;
   } rtcp_host_s;
endpackage

// ### hw/rtcp_link_if.sv
// rtcp_link_if: register link between host and clock device
// assumes: both ends share clk; req held until ack
`timescale 1ns/100ps
interface rtcp_link_if;
   logic req;
   logic we;
   logic burst;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic ack;
   modport dev (input req, input we, input burst, input addr,
      input wdata, output rdata, output ack);
   modport host (output req, output we, output burst, output addr,
      output wdata, input rdata, input ack);
endinterface

// ### hw/rtcp_host.sv
// rtcp_host: host end; keys, start-up settings, trim calc, burst limit
// assumes: user side and device share clk
`timescale 1ns/100ps
`include "rtcp_defs.svh"
module rtcp_host
   import rtcp_pkg::*;
#(
   parameter int BURST_CYC = `RTCP_BURST_CYC
)
(
   input wire logic clk,
   input wire logic srst,
   rtcp_link_if.host link,
   input wire logic cmd_valid,
   input wire logic cmd_we,
   input wire logic cmd_burst,
   input wire logic [7:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   input wire logic trim_start,
   input wire logic [19:0] trim_meas,
   output logic trim_reject
);
   rtcp_host_s q, d;
   logic signed [20:0] trim_steps;
   logic [9:0] a10;
   logic [1:0] coarse;
   logic mode;
   logic [6:0] ofs;

   //----------------------------------------------------------------
   // trim fields from measured frequency (Hz, 4 fraction bits)
   //----------------------------------------------------------------
   // steps = (nominal - measured) * 2^19 / nominal = 16 * offset in Hz
   assign trim_steps = $signed(`RTCP_NOM_Q4 - {1'b0, trim_meas}); // RULE_17
   assign a10 = trim_steps[9:0];
   always_comb begin
      coarse = 2'd0;
      mode = 1'b0;
      ofs = a10[6:0];
      if (trim_steps < -21'sd256) begin
         coarse = 2'd3; // RULE_19
         mode = 1'b1;
         ofs = 7'((a10 + 10'd192) >> 1) | {a10[9], 6'h00};
      end else if (trim_steps < -21'sd192) begin
         coarse = 2'd3;
         ofs = 7'(a10 + 10'd192);
      end else if (trim_steps < -21'sd128) begin
         coarse = 2'd2;
         ofs = 7'(a10 + 10'd128);
      end else if (trim_steps < -21'sd64) begin
         coarse = 2'd1;
         ofs = 7'(a10 + `RTCP_COARSE_STEP);
      end else if (trim_steps >= 21'sd64) begin
         mode = 1'b1;
         ofs = a10[7:1];
      end
   end

   //----------------------------------------------------------------
   // sequencer
   //----------------------------------------------------------------
   always_comb begin
      d = q;
      d.rsp_valid = 1'b0;
      d.reject = 1'b0;
      case (q.st)
         H_IDLE: begin
            d.i = 2'd0;
            if (trim_start) begin
               if (trim_steps < `RTCP_ADJ_MIN || trim_steps >= `RTCP_ADJ_MAX) begin
                  d.reject = 1'b1; // RULE_18
               end else begin
                  d.ops[0] = {1'b1, `RTCP_A_XTAL_TRIM, mode, ofs};
                  d.ops[1] = {1'b1, `RTCP_A_KEY, `RTCP_KEY_OSC}; // RULE_01
                  // crystal source, autoswitch kept on, coarse field
                  d.ops[2] = {1'b1, `RTCP_A_OSC_CTRL, 1'b0, coarse,
                     5'h10}; // RULE_16
                  d.n = 3'd3;
                  d.st = H_ISSUE;
               end
            end else if (cmd_valid) begin
               d.n = 3'd1;
               d.ops[0] = {cmd_we, cmd_addr, cmd_wdata};
               if (cmd_we && cmd_addr == `RTCP_A_SW_REF) begin
                  d.st = H_DONE; // RULE_11
               end else if (cmd_we && cmd_addr == `RTCP_A_OSC_CTRL) begin
                  d.ops[0] = {1'b1, `RTCP_A_KEY, `RTCP_KEY_OSC}; // RULE_01
                  d.ops[1] = {cmd_we, cmd_addr, cmd_wdata};
                  d.n = 3'd2;
                  d.st = H_ISSUE;
               end else if (cmd_we && (cmd_addr == `RTCP_A_CHARGE ||
                     cmd_addr == `RTCP_A_BUS_IO ||
                     cmd_addr == `RTCP_A_OUT_CTRL)) begin
                  d.ops[0] = {1'b1, `RTCP_A_KEY, `RTCP_KEY_MISC}; // RULE_02
                  d.ops[1] = {cmd_we, cmd_addr, cmd_wdata};
                  d.n = 3'd2;
                  d.st = H_ISSUE;
               end else begin
                  d.st = H_ISSUE;
               end
            end
         end
         H_ISSUE: begin
            if (link.ack) begin
               d.rsp_data = link.rdata;
               if (3'(q.i) + 3'd1 == q.n) begin
                  d.st = H_DONE;
               end else begin
                  d.i = q.i + 2'd1;
               end
            end
         end
         H_DONE: begin
            d.rsp_valid = 1'b1;
            d.st = H_IDLE;
         end
         default: begin
            d.st = H_IDLE;
         end
      endcase
      // burst held longer than the limit is cut short
      if (!cmd_burst) begin
         d.burst_to = 1'b0;
         d.cnt = '0;
      end else if (!q.burst_to) begin
         d.cnt = q.cnt + 18'd1;
         d.burst_to = (q.cnt >= 18'(BURST_CYC - 2)); // RULE_05
      end
   end

   //----------------------------------------------------------------
   // state register; start-up settings queued at reset
   //----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         q <= '0;
         q.st <= H_ISSUE;
         q.n <= 3'd4;
         q.ops[0] <= {1'b1, `RTCP_A_KEY, `RTCP_KEY_MISC}; // RULE_12
         q.ops[1] <= {1'b1, `RTCP_A_BUS_IO, 8'h00}; // RULE_12
         q.ops[2] <= {1'b1, `RTCP_A_KEY, `RTCP_KEY_OSC};
         q.ops[3] <= {1'b1, `RTCP_A_OSC_CTRL, 8'h10}; // RULE_10
      end else begin
         q <= d;
      end
   end

   //----------------------------------------------------------------
   // outputs
   //----------------------------------------------------------------
   assign link.req = (q.st == H_ISSUE);
   assign link.we = q.ops[q.i][16];
   assign link.addr = q.ops[q.i][15:8];
   assign link.wdata = q.ops[q.i][7:0];
   assign link.burst = cmd_burst && !q.burst_to;
   assign cmd_ready = (q.st == H_IDLE) && !trim_start;
   assign rsp_valid = q.rsp_valid;
   assign rsp_data = q.rsp_data;
   assign trim_reject = q.reject;
endmodule

// ### tb/rtcp_link_sva.sv
// rtcp_link_sva: link handshake and key pairing checks
// assumes: sits beside the link interface, one clock, sync reset
`timescale 1ns/100ps
module rtcp_link_sva #(
   parameter int BURST_CYC = 50
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic req,
   input wire logic we,
   input wire logic burst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic ack
);
   logic [7:0] key_q;
   logic [17:0] bcnt_q;
   logic wr;
   logic prot;
   // completed writes and protected targets
   assign wr = req && we && ack;
   assign prot = addr inside {8'h1c, 8'h20, 8'h21, 8'h27, 8'h30};
   // shadow key; one protected write uses it up
   always_ff @(posedge clk) begin
      if (srst) begin
         key_q <= 8'h00;
      end else if (wr && addr == 8'h1f) begin
         key_q <= wdata;
      end else if (wr && prot) begin
         key_q <= 8'h00;
      end
   end
   // burst length; a low burst line keeps it at zero
   always_ff @(posedge clk) begin
      if (srst || !burst) begin
         bcnt_q <= 18'h0;
      end else begin
         bcnt_q <= bcnt_q + 18'h1;
      end
   end
   //------------------------------------------------------------
   // properties
   //------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   ack_one_cycle_a: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   ack_prompt_a: assert property (req && !ack |=> ack)
      else $error("ack not one cycle after request");
   req_held_a: assert property (req && !ack |=> req && $stable(addr)
      && $stable(we) && $stable(wdata))
      else $error("request changed before ack");
   ack_has_req_a: assert property (ack |-> req)
      else $error("ack without request");
   osc_key_a: assert property (
      wr && addr == 8'h1c |-> key_q == 8'ha1)
      else $error("oscillator write without its key");
   misc_key_a: assert property (
      wr && addr inside {8'h20, 8'h27, 8'h30} |-> key_q == 8'h9d)
      else $error("protected write without its key");
   ref_kept_a: assert property (!(req && we && addr == 8'h21))
      else $error("threshold register written");
   burst_cut_a: assert property (bcnt_q <= BURST_CYC + 8)
      else $error("time burst held too long");
   time_pad_a: assert property (
      ack && !we && addr inside {[8'h04:8'h07]} |-> rdata == 8'h00)
      else $error("unused time byte not zero");
   cover property (wr && addr == 8'h1c);
   cover property (burst && ack);
   cover property (ack && !we && addr == 8'h0f);
endmodule

// ### tb/tb_rtc_protected_regs_and_trim.sv
// tb_rtc_protected_regs_and_trim: host and device joined, user side driven
// assumes: design files compiled first; 25 MHz clock, sync reset
`timescale 1ns/100ps
module tb_rtc_protected_regs_and_trim;
   import rtcp_pkg::*;
   logic clk = 0;
   logic srst = 1;
   logic cmd_valid = 0;
   logic cmd_we = 0;
   logic cmd_burst = 0;
   logic [7:0] cmd_addr = 0;
   logic [7:0] cmd_wdata = 0;
   logic trim_start = 0;
   logic [19:0] trim_meas = 0;
   logic xt_tick = 0;
   logic [7:0] event_set = 0;
   logic backup_power = 0;
   logic osc_on_rc = 0;
   logic cmd_ready, rsp_valid, trim_reject, chain_frozen, bus_disabled;
   logic output_b_level, backup_rc_autoswitch, osc_source_select, halt;
   logic [3:0] switchover_threshold;
   logic [7:0] rsp_data, charge_control, output_control, rd;
   int fails = 0;
   int n_tests = 0;
   int cyc = 0;
   // trim table: measured Hz*16, expected trim byte, expected osc ctrl
   logic [19:0] tm [5] = '{20'h80064, 20'h7ff9c, 20'h8012c, 20'h800c8,
      20'h80096};
   logic [7:0] tx [5] = '{8'h5c, 8'hb2, 8'hca, 8'h78, 8'h6a};
   logic [7:0] tc [5] = '{8'h30, 8'h10, 8'h70, 8'h70, 8'h50};
   rtcp_link_if link ();
   rtcp_dev u_rtcp_dev (.clk(clk), .srst(srst), .link(link),
      .xt_tick(xt_tick), .rc_tick(1'b0), .event_set(event_set),
      .backup_power(backup_power), .osc_on_rc(osc_on_rc), .seconds(),
      .second_pulse(), .chain_frozen(chain_frozen),
      .bus_disabled(bus_disabled), .output_b_level(output_b_level),
      .halt(halt), .backup_rc_autoswitch(backup_rc_autoswitch),
      .osc_source_select(osc_source_select),
      .switchover_threshold(switchover_threshold),
      .charge_control(charge_control), .output_control(output_control));
   rtcp_host #(.BURST_CYC(50)) u_rtcp_host (.clk(clk), .srst(srst),
      .link(link), .cmd_valid(cmd_valid), .cmd_we(cmd_we),
      .cmd_burst(cmd_burst), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .trim_start(trim_start), .trim_meas(trim_meas),
      .trim_reject(trim_reject));
   rtcp_link_sva #(.BURST_CYC(50)) u_rtcp_link_sva (.clk(clk),
      .srst(srst), .req(link.req), .we(link.we), .burst(link.burst),
      .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
      .ack(link.ack));
   // clock, shortened tick and hang guard
   always #20 clk = ~clk;
   always @(negedge clk) xt_tick <= !xt_tick;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fails++;
         tally_and_finish();
      end
   end
   //------------------------------------------------------------
   // tasks
   //------------------------------------------------------------
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s exp %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wait_ready();
      int k;
      k = 0;
      while (cmd_ready !== 1'b1 && k < 50) begin
         @(negedge clk);
         k++;
      end
   endtask
   // one user command; response is a one-cycle pulse, caught at negedge
   task automatic op(input logic w, input logic [7:0] a,
      input logic [7:0] d);
      int k;
      wait_ready();
      cmd_valid = 1;
      cmd_we = w;
      cmd_addr = a;
      cmd_wdata = d;
      @(negedge clk);
      cmd_valid = 0;
      k = 0;
      while (rsp_valid !== 1'b1 && k < 50) begin
         @(negedge clk);
         k++;
      end
      chk("rsp_valid", rsp_valid, 1);
      rd = rsp_data;
      @(negedge clk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      op(0, a, 8'h00);
      chk($sformatf("reg %h", a), rd, e);
   endtask
   task automatic trim(input logic [19:0] m, input logic rej);
      int k;
      wait_ready();
      trim_meas = m;
      trim_start = 1;
      @(negedge clk);
      trim_start = 0;
      k = 0;
      while (rsp_valid !== 1'b1 && trim_reject !== 1'b1 && k < 80) begin
         @(negedge clk);
         k++;
      end
      chk("trim_reject", trim_reject, rej);
      // a hang with no answer must not pass as a clean trim
      chk("trim_end", rsp_valid | trim_reject, 1);
      @(negedge clk);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   //------------------------------------------------------------
   // tests
   //------------------------------------------------------------
   initial begin
      repeat (2) @(negedge clk);
      srst = 0;
      // start-up settings made by the host
      wait_ready();
      chk("aos", backup_rc_autoswitch, 1);
      chk("switchover_threshold", switchover_threshold, 4'hf);
      rchk(8'h27, 8'h00);
      backup_power = 1;
      @(negedge clk);
      chk("bus_off", bus_disabled, 1);
      backup_power = 0;
      @(negedge clk);
      $display("test startup done");
      // flags: plain access, then clear on read with a fresh event
      op(1, 8'h0f, 8'ha5);
      rchk(8'h0f, 8'ha5);
      op(1, 8'h10, 8'h04);
      event_set = 8'h02;
      @(negedge clk);
      event_set = 8'h00;
      rchk(8'h0f, 8'ha7);
      rchk(8'h0f, 8'h80);
      op(1, 8'h10, 8'h00);
      $display("test flags done");
      // keyed registers; threshold write is refused
      op(1, 8'h20, 8'h5a);
      chk("charge", charge_control, 8'h5a);
      rchk(8'h1f, 8'h00);
      op(1, 8'h30, 8'hc0);
      chk("output_control_reg", output_control, 8'hc0);
      op(1, 8'h21, 8'h00);
      rchk(8'h21, 8'hf0);
      rchk(8'h1e, 8'h00);
      $display("test keys done");
      // output lock hides and guards output b
      op(1, 8'h10, 8'h20);
      chk("output_b_level", output_b_level, 1);
      op(1, 8'h1d, 8'h20);
      rchk(8'h10, 8'h00);
      op(1, 8'h10, 8'h00);
      chk("output_b_level_kept", output_b_level, 1);
      op(1, 8'h1d, 8'h00);
      rchk(8'h10, 8'h20);
      // running source shows only while not halted
      osc_on_rc = 1;
      rchk(8'h1d, 8'h10);
      op(1, 8'h10, 8'h80);
      chk("halt", halt, 1);
      rchk(8'h1d, 8'h00);
      op(1, 8'h10, 8'h00);
      osc_on_rc = 0;
      $display("test lock done");
      // burst freeze, release, and cut of an overlong burst
      cmd_burst = 1;
      for (int i = 0; i < 8; i++) begin
         rchk(i[7:0], 8'h00);
      end
      chk("frozen", chain_frozen, 1);
      cmd_burst = 0;
      repeat (3) @(negedge clk);
      chk("thawed", chain_frozen, 0);
      cmd_burst = 1;
      op(0, 8'h00, 8'h00);
      repeat (70) @(negedge clk);
      chk("cut", chain_frozen, 0);
      cmd_burst = 0;
      $display("test burst done");
      // trim: zero offset, every band, both out-of-range ends
      trim(20'h80000, 0);
      rchk(8'h14, 8'h00);
      rchk(8'h1c, 8'h10);
      chk("osc_source_select", osc_source_select, 0);
      foreach (tm[i]) begin
         trim(tm[i], 0);
         rchk(8'h14, tx[i]);
         rchk(8'h1c, tc[i]);
      end
      trim(20'h80141, 1);
      trim(20'h7ff80, 1);
      $display("test trim done");
      tally_and_finish();
   end
endmodule
